// ===== rtl/hpc_defs.svh
// Constants for the hub port interface: timing, rate codes, port map.
// Assumes a 40 MHz system clock and inclusion by bare name.
`ifndef HPC_DEFS_SVH
`define HPC_DEFS_SVH
// ************************************************************
// Timing
// ************************************************************
`define HPC_CLK_HZ 40000000
`define HPC_REF_BPS 2500000
`define HPC_OVERSAMPLE 8
`define HPC_IDLE_NS 5600
`define HPC_REF_BIT_NS 400
`define HPC_SAMP_BASE (`HPC_CLK_HZ / (`HPC_REF_BPS * `HPC_OVERSAMPLE))
`define HPC_IDLE_TICKS ((`HPC_IDLE_NS / `HPC_REF_BIT_NS) * `HPC_OVERSAMPLE)
`define HPC_SYNC_WAIT 2'h3
`define HPC_BIT_MID 3'h2 // Phase that samples inside a half-bit pulse
`define HPC_BIT_CLR 3'h6 // Phase that ends the regenerated pulse
// ************************************************************
// Rate codes
// ************************************************************
`define HPC_RATE_X1_MAX 3'h4
`define HPC_RATE_X2 3'h5
`define HPC_RATE_RSVD 3'h6
`define HPC_RATE_X4 3'h7
// ************************************************************
// Ports and groups
// ************************************************************
`define HPC_NPORT 5
`define HPC_PORT_EXP 3'h4
`define HPC_GRP_A 2'h0
`define HPC_GRP_B 2'h1
`define HPC_GRP_E 2'h2
`endif

// ===== rtl/hpc_pkg.sv
// Types shared by the hub port interface modules.
// Assumes hpc_defs.svh is not needed here.
package hpc_pkg;
  // Direction control states
  typedef enum logic {
    DIR_IDLE,
    DIR_HOLD
  } hpc_dir_t;
endpackage : hpc_pkg

// ===== rtl/hpc_rate_gen.sv
// Rate decoder: turns the captured rate code into an oversampling tick.
// Assumes a 40 MHz clock; codes at or above 5 Mbps clamp to one cycle.
`timescale 1ns/1ps
`include "hpc_defs.svh"
module hpc_rate_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] rate_sel_i,
  output logic samp_tick_o,
  output logic reserved_o
);
  // Sampling period in clocks for a rate code
  function automatic logic [5:0] samp_period(input logic [2:0] code);
    logic [5:0] p;
    p = 6'h1;
    if (code <= `HPC_RATE_X1_MAX) begin
      p = 6'(`HPC_SAMP_BASE << (`HPC_RATE_X1_MAX - code));
    end else if (code == `HPC_RATE_RSVD) begin
      p = 6'(`HPC_SAMP_BASE);
    end
    return p;
  endfunction : samp_period

  logic [5:0] cnt_r; // Clocks since last tick
  logic [5:0] period;

  assign period = samp_period(rate_sel_i);
  // Reserved code has no defined speed; flag it, run at the base rate
  assign reserved_o = (rate_sel_i == `HPC_RATE_RSVD);

  // Free-running divider, wraps at the selected period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 6'h0;
    end else if (cnt_r >= period - 6'h1) begin
      cnt_r <= 6'h0;
    end else begin
      cnt_r <= cnt_r + 6'h1;
    end
  end
  assign samp_tick_o = (cnt_r >= period - 6'h1);

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_tick_o && $stable(rate_sel_i) && rate_sel_i == 3'h4) |=> !samp_tick_o)
    else $error("tick spacing wrong at base rate");
endmodule : hpc_rate_gen

// ===== rtl/hpc_rx_cond.sv
// Receive conditioner for one port: sync, polarity, noise cut, edge.
// Assumes samp_tick_i pulses at eight times the data rate.
`timescale 1ns/1ps
module hpc_rx_cond #(
  parameter int NCUT_LEN = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rx_pin_i,
  input wire logic pol_i,
  input wire logic ncut_en_i,
  input wire logic samp_tick_i,
  output logic act_o,
  output logic rise_o
);
  logic s1_r, s2_r, s3_r; // Three-stage synchroniser
  logic lvl_r; // Level accepted once stages two and three agree
  logic filt_r; // Conditioned active level
  logic prev_r; // Last level for edge detect
  logic [1:0] run_r; // Consecutive disagreeing samples
  logic raw_act;

  // Synchroniser; stage one feeds stage two only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      lvl_r <= 1'b1;
    end else begin
      s1_r <= rx_pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        lvl_r <= s3_r;
      end
    end
  end

  // Strap 0 means active high, 1 means active low
  assign raw_act = lvl_r ^ pol_i;

  // Sampled at the 8x tick; noise cut needs a run of equal samples
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_r <= 1'b0;
      run_r <= 2'h0;
    end else if (samp_tick_i) begin
      if (raw_act == filt_r) begin
        run_r <= 2'h0;
      end else if (!ncut_en_i || run_r >= 2'(NCUT_LEN - 1)) begin
        filt_r <= raw_act;
        run_r <= 2'h0;
      end else begin
        run_r <= run_r + 2'h1;
      end
    end
  end

  // Rising edge of the conditioned level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= filt_r;
    end
  end
  assign act_o = filt_r;
  assign rise_o = filt_r & ~prev_r;

  a_ncut_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (samp_tick_i && !ncut_en_i && raw_act != filt_r) |=> (filt_r == $past(raw_act)))
    else $error("noise cut off but level not passed");
endmodule : hpc_rx_cond

// ===== rtl/hpc_hub_port.sv
// Hub port interface: five receive ports, direction control, regenerated
// transmit pulses and strap-driven line polarity and kind.
// Assumes straps are static board levels and receive pins are asynchronous.
//
// Contract
// - Receive polarity strap: 0 high, 1 low
// - Transmit kind strap: 0 pulses, 1 enable
// - Pulse line is enable OR bus pulse
// - Transmit polarity strap: 0 low, 1 high
// - Coax pulse pair always active low
// - Backplane pulse output always active low
// - Rate code selects divisor and multiplier
// - Noise cut strap 0 filters receive data
// - Big jitter strap 0 uses second pulse
// - Expansion strap 0 open drain, 1 driven
// - First active port receives, others transmit
// - Release direction after 5.6 us silence; here after 112 sample ticks, which is 5.6 us only at rate codes 4 and 6
// - Receive sampled at eight times data rate; code 7 clamps to one tick per clock, four times its rate
`timescale 1ns/1ps
`include "hpc_defs.svh"
module hpc_hub_port (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic [1:0] RX_IN_GRP_A_I,
  input wire logic [1:0] RX_IN_GRP_B_I,
  input wire logic RX_IN_EXPANSION_I,
  input wire logic RX_POL_GRP_A_I,
  input wire logic RX_POL_GRP_B_I,
  input wire logic RX_POL_EXPANSION_I,
  input wire logic TX_POL_GRP_A_I,
  input wire logic TX_POL_GRP_B_I,
  input wire logic TX_POL_EXPANSION_I,
  input wire logic TX_KIND_GRP_A_I,
  input wire logic TX_KIND_GRP_B_I,
  input wire logic TX_KIND_EXPANSION_I,
  input wire logic [2:0] RATE_SEL_I,
  input wire logic NOISE_CUT_FIRST_LOW_I,
  input wire logic NOISE_CUT_SECOND_LOW_I,
  input wire logic NOISE_CUT_EXPANSION_LOW_I,
  input wire logic JITTER_REF_FIRST_LOW_I,
  input wire logic JITTER_REF_SECOND_LOW_I,
  input wire logic JITTER_REF_EXPANSION_LOW_I,
  input wire logic EXPANSION_OPENDRAIN_LOW_I,
  output logic [1:0] TX_OUT_GRP_A_O,
  output logic [1:0] TX_OUT_GRP_B_O,
  output logic TX_OUT_EXPANSION_O,
  output logic TX_OUT_EXPANSION_OE_O,
  output logic [1:0] COAX_DRIVE_PAIR_N_O,
  output logic BUS_DRIVE_OUT_N_O,
  output logic DIR_HOLD_O,
  output logic [2:0] SRC_PORT_O,
  output logic RATE_RESERVED_O
);
  // ************************************************************
  // Helpers
  // ************************************************************
  // Group of a port index: A0,A1 -> A; B0,B1 -> B; 4 -> expansion
  function automatic logic [1:0] port_grp(input int idx);
    logic [1:0] g;
    g = `HPC_GRP_E;
    if (idx < 2) begin
      g = `HPC_GRP_A;
    end else if (idx < 4) begin
      g = `HPC_GRP_B;
    end
    return g;
  endfunction : port_grp

  // ************************************************************
  // Strap capture
  // ************************************************************
  localparam int NSTRAP = 19;
  logic [NSTRAP-1:0] strap_pin; // Raw strap pins
  logic [NSTRAP-1:0] st1_r, st2_r, st3_r; // Strap synchroniser
  logic [NSTRAP-1:0] cfg_r; // Captured configuration
  logic [1:0] wait_r; // Edges since reset release
  logic cfg_ok_r; // Configuration valid

  assign strap_pin = {RATE_SEL_I, EXPANSION_OPENDRAIN_LOW_I,
    JITTER_REF_EXPANSION_LOW_I, JITTER_REF_SECOND_LOW_I, JITTER_REF_FIRST_LOW_I,
    NOISE_CUT_EXPANSION_LOW_I, NOISE_CUT_SECOND_LOW_I, NOISE_CUT_FIRST_LOW_I,
    TX_KIND_EXPANSION_I, TX_KIND_GRP_B_I, TX_KIND_GRP_A_I,
    TX_POL_EXPANSION_I, TX_POL_GRP_B_I, TX_POL_GRP_A_I,
    RX_POL_EXPANSION_I, RX_POL_GRP_B_I, RX_POL_GRP_A_I};

  // Straps pass the sync chain, then are frozen once after release;
  // later board changes are deliberately ignored until the next reset
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      st1_r <= '0;
      st2_r <= '0;
      st3_r <= '0;
      cfg_r <= '0;
      wait_r <= 2'h0;
      cfg_ok_r <= 1'b0;
    end else begin
      st1_r <= strap_pin;
      st2_r <= st1_r;
      st3_r <= st2_r;
      if (!cfg_ok_r && wait_r == `HPC_SYNC_WAIT && st2_r == st3_r) begin
        cfg_r <= st3_r;
        cfg_ok_r <= 1'b1;
      end else if (wait_r != `HPC_SYNC_WAIT) begin
        wait_r <= wait_r + 2'h1;
      end
    end
  end

  // Per-group views of the captured straps
  logic [2:0] rx_pol, tx_pol, tx_kind, ncut_n, bj_n;
  logic od_n;
  logic [2:0] rate_cfg;
  assign rx_pol = cfg_r[2:0];
  assign tx_pol = cfg_r[5:3];
  assign tx_kind = cfg_r[8:6];
  assign ncut_n = cfg_r[11:9];
  assign bj_n = cfg_r[14:12];
  assign od_n = cfg_r[15];
  assign rate_cfg = cfg_r[18:16];

  // ************************************************************
  // Rate and receive conditioning
  // ************************************************************
  logic samp_tick; // Eight times the data rate, four times at rate code 7
  logic [`HPC_NPORT-1:0] rx_pin, rx_act, rx_rise;

  hpc_rate_gen u_rate (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .rate_sel_i(rate_cfg),
    .samp_tick_o(samp_tick),
    .reserved_o(RATE_RESERVED_O)
  );

  assign rx_pin = {RX_IN_EXPANSION_I, RX_IN_GRP_B_I, RX_IN_GRP_A_I};

  for (genvar gi = 0; gi < `HPC_NPORT; gi++) begin : g_rx
    hpc_rx_cond #(.NCUT_LEN(2)) u_cond (
      .clk_i(CLK_SYS_I),
      .rst_i(RESET_I),
      .rx_pin_i(rx_pin[gi]),
      .pol_i(rx_pol[port_grp(gi)]),
      .ncut_en_i(~ncut_n[port_grp(gi)]),
      .samp_tick_i(samp_tick),
      .act_o(rx_act[gi]),
      .rise_o(rx_rise[gi])
    );
  end

  // ************************************************************
  // Direction control
  // ************************************************************
  hpc_pkg::hpc_dir_t dir_r; // Idle or holding a source
  logic [2:0] src_r; // Receiving port
  logic [6:0] quiet_r; // Silent sample ticks
  logic [2:0] first_rise; // Lowest port with a new edge
  logic src_act, src_rise;

  // Lowest index wins when two ports start together
  always_comb begin
    first_rise = 3'h0;
    for (int i = `HPC_NPORT - 1; i >= 0; i--) begin
      if (rx_rise[i]) begin
        first_rise = 3'(i);
      end
    end
  end
  assign src_act = rx_act[src_r];
  assign src_rise = rx_rise[src_r];

  // Lock on the first active receiver, release after the quiet interval
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      dir_r <= hpc_pkg::DIR_IDLE;
      src_r <= 3'h0;
      quiet_r <= 7'h0;
    end else begin
      case (dir_r)
        hpc_pkg::DIR_IDLE: begin
          quiet_r <= 7'h0;
          if (cfg_ok_r && |rx_rise) begin
            dir_r <= hpc_pkg::DIR_HOLD;
            src_r <= first_rise;
          end
        end
        hpc_pkg::DIR_HOLD: begin
          if (src_act) begin
            quiet_r <= 7'h0;
          end else if (samp_tick) begin
            if (quiet_r >= 7'(`HPC_IDLE_TICKS - 1)) begin
              dir_r <= hpc_pkg::DIR_IDLE;
              quiet_r <= 7'h0;
            end else begin
              quiet_r <= quiet_r + 7'h1;
            end
          end
        end
        default: begin
          dir_r <= hpc_pkg::DIR_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Regeneration
  // ************************************************************
  logic [1:0] pcnt_r; // Source pulses since lock, saturating
  logic ref_ok; // Phase reference established
  logic [2:0] ph_r; // Sample phase inside a bit
  logic regen_r; // Regenerated bit level
  logic bj_sel;

  assign bj_sel = ~bj_n[port_grp(int'(src_r))];
  // Big jitter mode waits for the second pulse as phase reference
  assign ref_ok = (pcnt_r >= (bj_sel ? 2'h2 : 2'h1));

  // Count source pulses; phase restarts on the reference pulse
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      pcnt_r <= 2'h0;
      ph_r <= 3'h0;
    end else if (dir_r != hpc_pkg::DIR_HOLD) begin
      pcnt_r <= 2'h0;
      ph_r <= 3'h0;
    end else if (src_rise && !ref_ok) begin
      pcnt_r <= pcnt_r + 2'h1;
      ph_r <= 3'h0;
    end else if (samp_tick) begin
      ph_r <= ph_r + 3'h1;
    end
  end

  // Sample inside the pulse, drop half a bit later: one pulse per bit
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      regen_r <= 1'b0;
    end else if (dir_r != hpc_pkg::DIR_HOLD) begin
      regen_r <= 1'b0;
    end else if (samp_tick && (ph_r == `HPC_BIT_MID || ph_r == `HPC_BIT_CLR)) begin
      regen_r <= src_act & ref_ok & (ph_r == `HPC_BIT_MID);
    end
  end

  // ************************************************************
  // Transmit drive
  // ************************************************************
  logic [`HPC_NPORT-1:0] txen_low; // Internal active-low enable
  logic [`HPC_NPORT-1:0] tx_lvl; // Active-low line before polarity
  logic [`HPC_NPORT-1:0] tx_r; // Registered line level
  logic pulse_n; // Active-low regenerated pulse

  assign pulse_n = ~regen_r;

  // Transmit only on non-source ports while holding
  always_comb begin
    for (int i = 0; i < `HPC_NPORT; i++) begin
      txen_low[i] = ~((dir_r == hpc_pkg::DIR_HOLD) && (3'(i) != src_r));
      if (tx_kind[port_grp(i)]) begin
        tx_lvl[i] = txen_low[i];
      end else begin
        tx_lvl[i] = txen_low[i] | pulse_n;
      end
    end
  end

  // Polarity applied in the output flops
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      tx_r <= '1;
    end else begin
      for (int i = 0; i < `HPC_NPORT; i++) begin
        tx_r[i] <= tx_lvl[i] ^ tx_pol[port_grp(i)];
      end
    end
  end

  // Fixed active-low pulse outputs, gated by the hold state
  logic pulse_n_r;
  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      pulse_n_r <= 1'b1;
    end else begin
      pulse_n_r <= pulse_n;
    end
  end

  assign COAX_DRIVE_PAIR_N_O = {2{pulse_n_r}};
  assign BUS_DRIVE_OUT_N_O = pulse_n_r;
  assign TX_OUT_GRP_A_O = tx_r[1:0];
  assign TX_OUT_GRP_B_O = tx_r[3:2];
  // Open drain only ever pulls low; released line idles high externally
  assign TX_OUT_EXPANSION_O = od_n ? tx_r[`HPC_PORT_EXP] : 1'b0;
  assign TX_OUT_EXPANSION_OE_O = od_n ? 1'b1 : ~tx_r[`HPC_PORT_EXP];
  assign DIR_HOLD_O = (dir_r == hpc_pkg::DIR_HOLD);
  assign SRC_PORT_O = src_r;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_idle_rise;
    dir_r == hpc_pkg::DIR_IDLE && cfg_ok_r && |rx_rise;
  endsequence
  sequence s_hold_src;
    dir_r == hpc_pkg::DIR_HOLD && src_r == $past(first_rise);
  endsequence

  a_lock_first: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    s_idle_rise |=> s_hold_src)
    else $error("direction did not lock on first edge");
  a_src_silent: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (dir_r == hpc_pkg::DIR_HOLD && $stable(src_r)) |=>
      (tx_r[$past(src_r)] != tx_pol[port_grp(int'($past(src_r)))]))
    else $error("source port echoes transmit");
  a_release_time: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (dir_r == hpc_pkg::DIR_HOLD && !src_act && samp_tick &&
      quiet_r == 7'(`HPC_IDLE_TICKS - 1)) |=> dir_r == hpc_pkg::DIR_IDLE)
    else $error("release not at quiet interval");
  a_no_early_rel: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (dir_r == hpc_pkg::DIR_HOLD && src_act) |=> dir_r == hpc_pkg::DIR_HOLD)
    else $error("released while source active");
  a_coax_match: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    COAX_DRIVE_PAIR_N_O[0] == BUS_DRIVE_OUT_N_O && COAX_DRIVE_PAIR_N_O[1] == BUS_DRIVE_OUT_N_O)
    else $error("pulse outputs disagree");
  a_idle_quiet: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (dir_r == hpc_pkg::DIR_IDLE) |=> ##1 BUS_DRIVE_OUT_N_O)
    else $error("pulse while idle");
  a_cfg_frozen: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    $past(cfg_ok_r) |-> $stable(cfg_r))
    else $error("straps changed after capture");
  a_od_low_only: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (!od_n && TX_OUT_EXPANSION_OE_O) |-> !TX_OUT_EXPANSION_O)
    else $error("open drain drives high");
  a_bj_wait: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (bj_sel && pcnt_r < 2'h2) |=> ##1 !regen_r)
    else $error("regenerated before second pulse");
endmodule : hpc_hub_port

// ===== dv/hpc_media_model.sv
// Media transceiver model: drives the five receive pins with pulse bursts.
// Assumes the caller gives bit and pulse lengths in system clocks.
`timescale 1ns/1ps
module hpc_media_model (
  input wire logic clk_i,
  output logic [4:0] rx_o
);
  // ************************************************************
  // Line state
  // ************************************************************
  logic idle_lvl = 1'b0; // Inactive pin level for the strapped polarity
  initial rx_o = 5'h00;

  // Park every pin at the inactive level of the given polarity
  task automatic set_idle(input logic pol);
    idle_lvl = pol;
    rx_o <= {5{pol}};
  endtask : set_idle

  // One pulse per bit cell, all ones; automatic so two ports can talk at once
  task automatic burst(input int p, input int nbits, input int bit_clks, input int w_clks);
    for (int b = 0; b < nbits; b++) begin
      @(posedge clk_i);
      rx_o[p] <= ~idle_lvl;
      repeat (w_clks) @(posedge clk_i);
      rx_o[p] <= idle_lvl;
      repeat (bit_clks - w_clks - 1) @(posedge clk_i);
    end
  endtask : burst
endmodule : hpc_media_model

// ===== dv/hpc_hub_port_tb.sv
// Self-checking bench for the hub port interface: strap table, then edge cases.
// Assumes the media model owns the receive pins and straps are set in reset.
`timescale 1ns/1ps
module hpc_hub_port_tb;
  // ************************************************************
  // Signals
  // ************************************************************
  typedef struct packed {
    logic [2:0] rate;
    logic rxp;
    logic txp;
    logic kind;
    logic ncut_n;
    logic bj_n;
    logic od_n;
    logic [2:0] src;
    logic [3:0] nbits;
    logic [9:0] per; // Clocks per regenerated bit
    logic rsv;
  } hpc_row_t;
  // Rate, rx pol, tx pol, kind, noise cut, jitter, open drain, source, bits, period, reserved
  hpc_row_t rows [8] = '{
    '{3'h4, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 3'h0, 4'h6, 10'h010, 1'b0},
    '{3'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h4, 4'h4, 10'h100, 1'b0},
    '{3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 3'h3, 4'h5, 10'h020, 1'b0},
    '{3'h5, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h2, 4'h8, 10'h008, 1'b0},
    '{3'h7, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h1, 4'h8, 10'h008, 1'b0},
    '{3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0, 4'h5, 10'h080, 1'b0},
    '{3'h2, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h4, 4'h5, 10'h040, 1'b0},
    '{3'h6, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h1, 4'h6, 10'h010, 1'b1}
  };
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] rx; // Receive pins, driven by the media model
  logic [2:0] rate = 3'h4;
  logic rxp = 1'b0;
  logic txp = 1'b0;
  logic txp_a = 1'b0; // Separate so a late strap change can be tried
  logic kind = 1'b1;
  logic ncut_n = 1'b0;
  logic bj_n = 1'b1;
  logic od_n = 1'b1;
  logic [1:0] tx_a, tx_b, coax;
  logic tx_e, tx_oe, bus, hold, rsv;
  logic [2:0] src, src_seen;
  hpc_row_t cr; // Row under test, read by the monitor
  logic mon = 1'b0;
  logic bus_q, obs_q;
  int cnt [6]; // Bus edges, line edges, period, source, enable, coax faults
  int cyc, last_edge, hold_cnt;
  int n_errors = 0;
  int checked = 0;

  hpc_media_model med (.clk_i(clk), .rx_o(rx));

  hpc_hub_port dut (
    .CLK_SYS_I(clk), .RESET_I(rst), .RX_IN_GRP_A_I(rx[1:0]), .RX_IN_GRP_B_I(rx[3:2]),
    .RX_IN_EXPANSION_I(rx[4]), .RX_POL_GRP_A_I(rxp), .RX_POL_GRP_B_I(rxp),
    .RX_POL_EXPANSION_I(rxp), .TX_POL_GRP_A_I(txp_a), .TX_POL_GRP_B_I(txp),
    .TX_POL_EXPANSION_I(txp), .TX_KIND_GRP_A_I(kind), .TX_KIND_GRP_B_I(kind),
    .TX_KIND_EXPANSION_I(kind), .RATE_SEL_I(rate), .NOISE_CUT_FIRST_LOW_I(ncut_n),
    .NOISE_CUT_SECOND_LOW_I(ncut_n), .NOISE_CUT_EXPANSION_LOW_I(ncut_n),
    .JITTER_REF_FIRST_LOW_I(bj_n), .JITTER_REF_SECOND_LOW_I(bj_n),
    .JITTER_REF_EXPANSION_LOW_I(bj_n), .EXPANSION_OPENDRAIN_LOW_I(od_n),
    .TX_OUT_GRP_A_O(tx_a), .TX_OUT_GRP_B_O(tx_b), .TX_OUT_EXPANSION_O(tx_e),
    .TX_OUT_EXPANSION_OE_O(tx_oe), .COAX_DRIVE_PAIR_N_O(coax), .BUS_DRIVE_OUT_N_O(bus),
    .DIR_HOLD_O(hold), .SRC_PORT_O(src), .RATE_RESERVED_O(rsv)
  );

  // 40 MHz system clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  // Wire level of a transmit line; an open-drain line floats to the pull-up
  function automatic logic line(input int i);
    if (i < 2) begin
      return tx_a[i];
    end else if (i < 4) begin
      return tx_b[i - 2];
    end
    return tx_oe ? tx_e : 1'b1;
  endfunction : line

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Straps only count when set in reset: they are frozen just after release
  task automatic cfg(input hpc_row_t r);
    @(posedge clk);
    rst <= 1'b1;
    rate <= r.rate;
    rxp <= r.rxp;
    txp <= r.txp;
    txp_a <= r.txp;
    kind <= r.kind;
    ncut_n <= r.ncut_n;
    bj_n <= r.bj_n;
    od_n <= r.od_n;
    med.set_idle(r.rxp);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
  endtask : cfg

  // ************************************************************
  // Monitor: sampled on the falling edge, where outputs are settled
  // ************************************************************
  always @(negedge clk) begin
    if (mon) begin
      cyc++;
      if (coax !== {2{bus}}) cnt[5]++;
      if (bus === 1'b0 && bus_q === 1'b1) begin
        cnt[0]++;
        if (cnt[0] > 1 && cyc - last_edge != int'(cr.per)) cnt[2]++;
        last_edge = cyc;
      end
      bus_q = bus;
      if (line(cr.src == 3'h0) === cr.txp && obs_q !== cr.txp) cnt[1]++;
      obs_q = line(cr.src == 3'h0);
      hold_cnt = (hold === 1'b1) ? hold_cnt + 1 : 0;
      if (hold_cnt == 1) src_seen = src;
      for (int i = 0; i < 5 && hold_cnt >= 2; i++) begin
        if (i == int'(cr.src)) begin
          if (line(i) !== ~cr.txp) cnt[3]++;
        end else if (cr.kind && line(i) !== cr.txp) begin
          cnt[4]++;
        end
      end
    end
  end

  // One strap row: idle checks, a burst from the source port, release
  task automatic run_row(input hpc_row_t r);
    int w;
    int tick;
    tick = int'(r.per) / 8;
    cfg(r);
    chk(hold, 1'b0);
    chk(rsv, r.rsv);
    chk(tx_oe, r.od_n);
    chk({line(4), line(3), line(2), line(1), line(0)}, {5{~r.txp}});
    cr = r;
    cnt = '{default: 0};
    bus_q = 1'b1;
    obs_q = ~r.txp;
    mon = 1'b1;
    med.burst(int'(r.src), int'(r.nbits), int'(r.per), 4 * tick);
    w = 0;
    while (hold === 1'b1 && w < 5000) begin
      @(posedge clk);
      w++;
    end
    repeat (2) @(negedge clk);
    mon = 1'b0;
    chk(src_seen, r.src);
    chk(w >= 100 * tick && w <= 125 * tick + 20, 1'b1);
    chk({line(4), line(3), line(2), line(1), line(0), bus}, {{5{~r.txp}}, 1'b1});
    chk(cnt[3], 0);
    chk(cnt[4], 0);
    chk(cnt[5], 0);
    chk(cnt[2], 0);
    chk(cnt[0], r.nbits - (r.bj_n ? 1 : 2));
    chk(cnt[1], r.kind ? 1 : r.nbits - (r.bj_n ? 1 : 2));
  endtask : run_row

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    hpc_row_t r;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[k]) run_row(rows[k]);
    // A second port talking during a hold is not heard
    cfg(rows[4]);
    fork
      med.burst(1, 8, 8, 4);
      begin
        repeat (20) @(posedge clk);
        med.burst(0, 2, 8, 4);
      end
    join
    @(negedge clk);
    chk({hold, src, tx_a[0]}, {1'b1, 3'h1, 1'b1});
    // A one-tick glitch is cut with noise cut on, heard with it off
    r = rows[0];
    r.rate = 3'h0;
    r.ncut_n = 1'b0;
    cfg(r);
    med.burst(2, 1, 32, 32);
    repeat (300) @(posedge clk);
    chk(hold, 1'b0);
    r.ncut_n = 1'b1;
    cfg(r);
    med.burst(2, 1, 32, 32);
    repeat (150) @(negedge clk);
    chk({hold, src}, {1'b1, 3'h2});
    // A polarity strap moved after capture changes nothing
    cfg(rows[0]);
    @(posedge clk);
    txp_a <= 1'b1;
    repeat (5) @(negedge clk);
    chk(tx_a, 2'h3);
    // Reset in mid-hold returns every output to its reset level
    med.burst(0, 3, 16, 8);
    chk(hold, 1'b1);
    rst <= 1'b1;
    @(negedge clk);
    chk({tx_a, tx_b, tx_e, tx_oe, coax, bus, hold, src}, 13'h1E70);
    results();
  end

  // Watchdog: the whole sequence needs well under 30000 clocks
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule : hpc_hub_port_tb
